// [src/oesc_pkg.sv]
// Shared constants and types of the exposure sequencer and pin sync control
package oesc_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_HZ = 125_000_000;
	localparam int OSC_HZ = 32768;
	localparam int OSC_DIV = CLK_HZ / OSC_HZ;
	localparam logic [11:0] OSC_DIV_LAST = 12'(OSC_DIV - 1);

	// ************************************************************
	// Register byte addresses
	// ************************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SLOTS = 8'h04;
	localparam logic [7:0] ADDR_TIMING = 8'h08;
	localparam logic [7:0] ADDR_SYNC = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_SIMUL_BIT = 1;
	localparam int CTRL_AMB_BIT = 2;
	localparam int CTRL_NSLOT_LSB = 4;
	localparam int TIMING_PER_LSB = 16;
	localparam int STATUS_SLOT_LSB = 4;
	localparam int STATUS_BUSY_BIT = 8;
	localparam int STATUS_CNT_LSB = 16;
	localparam logic [5:0] CTRL_RESET = 6'h10;
	localparam logic [11:0] SLOTS_RESET = 12'h001;
	localparam logic [7:0] EXP_TICKS_RESET = 8'h02;
	localparam logic [15:0] PERIOD_RESET = 16'h0147;
	localparam logic [3:0] MODE_RESET = 4'h0;

	// ************************************************************
	// Pin modes, slot codes, FIFO tags, bus answers
	// ************************************************************
	localparam logic [3:0] MODE_ALONE_INT = 4'h0;
	localparam logic [3:0] MODE_ALONE_EXT = 4'h1;
	localparam logic [3:0] MODE_SLAVE_INT = 4'h2;
	localparam logic [3:0] MODE_SLAVE_EXT = 4'h3;
	localparam logic [3:0] MODE_MASTER_INT = 4'h4;
	localparam logic [3:0] MODE_MASTER_EXT = 4'h5;
	localparam logic [3:0] CODE_EMITTER_ONE = 4'h1;
	localparam logic [3:0] CODE_EMITTER_TWO = 4'h2;
	localparam logic [3:0] CODE_EMITTER_THREE = 4'h3;
	localparam logic [3:0] CODE_MUXED_FOUR = 4'hA;
	localparam logic [3:0] CODE_MUXED_FIVE = 4'hB;
	localparam logic [3:0] CODE_MUXED_SIX = 4'hC;
	localparam logic [4:0] TAG_EXPOSURE_BASE = 5'h01;
	localparam logic [4:0] TAG_AMBIENT = 5'h07;
	localparam int TAG_W = 5;
	localparam int CONV_W = 19;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DARK = 2'b01,
		ST_LIT = 2'b10,
		ST_AMB = 2'b11
	} oesc_state_e;

	typedef struct packed {
		logic o;
		logic oe;
	} oesc_pin_s;

	typedef struct packed {
		logic valid;
		logic [TAG_W-1:0] tag;
		logic [CONV_W-1:0] value;
	} oesc_fifo_s;

endpackage : oesc_pkg

// [src/oesc_pin_sync.sv]
// Two-stage pin synchroniser with rising edge detect
`timescale 1ns/1ps
module oesc_pin_sync (
	input wire logic i_mclk, // System clock
	input wire logic i_reset, // Async reset, active high
	input wire logic i_pin, // Asynchronous pin level
	output logic o_level, // Synchronised level
	output logic o_rise // One-cycle pulse on rising edge
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic last;
	} oesc_sync_s;

	oesc_sync_s q;

	// Meta stage feeds only the sync stage
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			q <= '0;
		end else begin
			q <= '{meta: i_pin, sync: q.meta, last: q.sync};
		end
	end

	assign o_level = q.sync;
	assign o_rise = q.sync & ~q.last;
endmodule : oesc_pin_sync

// [src/oesc_top.sv]
// Exposure sequencer and multipurpose pin control with AXI4-Lite registers
//
// Notes on behaviour
// - Every lit exposure has its dark level subtracted before the result is kept.
// - One to three emitters pulse one after another or all together.
// - Optional emitter-off ambient exposure after the lit exposures of a sample.
// - One slot, ambient off: exactly one result pushed per sample.
// - Emitters together, ambient on: combined result then ambient result pushed.
// - Emitters in turn, ambient on: results in slot order, then ambient.
// - A 4-bit mode field in the sync register selects both pin functions.
// - Mux pin driven only if a slot is muxed; low during muxed exposures.
// - Mode 0000: pin one mux control, pin two off, internal timing.
// - Mode 0001: pin one mux control, pin two external timing clock.
// - Mode 0010: pin one trigger input, pin two mux, internal exposures.
// - Mode 0011: pin one trigger input, pin two clocks the exposures.
// - Mode 0100: pin one master sample output, pin two mux, internal timing.
// - Mode 0101: pin one master sample output, pin two external clock.
// - A slave starts each sample on the master's sample timing.
// - Slot codes A, B, C select muxed emitters four, five, six.
// - A FIFO entry holds a 5-bit tag above a 19-bit value.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module oesc_top import oesc_pkg::*; (
	input wire logic i_mclk, // System clock, 125 MHz
	input wire logic i_reset, // Async reset, active high
	input wire logic [7:0] i_s_axi_awaddr, // Write address
	input wire logic i_s_axi_awvalid, // Write address valid
	output logic o_s_axi_awready, // Write address ready
	input wire logic [31:0] i_s_axi_wdata, // Write data
	input wire logic [3:0] i_s_axi_wstrb, // Write byte strobes
	input wire logic i_s_axi_wvalid, // Write data valid
	output logic o_s_axi_wready, // Write data ready
	output logic [1:0] o_s_axi_bresp, // Write response
	output logic o_s_axi_bvalid, // Write response valid
	input wire logic i_s_axi_bready, // Write response ready
	input wire logic [7:0] i_s_axi_araddr, // Read address
	input wire logic i_s_axi_arvalid, // Read address valid
	output logic o_s_axi_arready, // Read address ready
	output logic [31:0] o_s_axi_rdata, // Read data
	output logic [1:0] o_s_axi_rresp, // Read response
	output logic o_s_axi_rvalid, // Read data valid
	input wire logic i_s_axi_rready, // Read data ready
	input wire logic i_multipurpose_pin_one, // Pin one input level
	output logic o_multipurpose_pin_one, // Pin one output level
	output logic o_multipurpose_pin_one_oe, // Pin one drive enable
	input wire logic i_multipurpose_pin_two, // Pin two input level
	output logic o_multipurpose_pin_two, // Pin two output level
	output logic o_multipurpose_pin_two_oe, // Pin two drive enable
	output logic [2:0] o_emitter, // Emitter drivers one..three
	input wire logic [CONV_W-1:0] i_conv_data, // Converter value
	output logic o_fifo_valid, // FIFO write strobe
	output logic [23:0] o_fifo_data // FIFO entry: tag and value
);
	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [5:0] ctrl;
		logic [11:0] slots;
		logic [7:0] exp_ticks;
		logic [15:0] period;
		logic [3:0] mode;
		oesc_state_e st;
		logic [1:0] slot;
		logic [11:0] div_cnt;
		logic [7:0] tick_cnt;
		logic [15:0] per_cnt;
		logic [15:0] smp_cnt;
		logic [CONV_W-1:0] dark;
		logic trig_pend;
		oesc_pin_s pin1;
		oesc_pin_s pin2;
		logic [2:0] emit;
		oesc_fifo_s fifo;
		logic aw_have;
		logic [7:0] awaddr;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} oesc_state_s;

	oesc_state_s q;
	oesc_state_s n;
	logic p1_rise;
	logic p2_rise;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	oesc_pin_sync u_sync_one (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_pin(i_multipurpose_pin_one),
		.o_level(),
		.o_rise(p1_rise)
	);

	oesc_pin_sync u_sync_two (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_pin(i_multipurpose_pin_two),
		.o_level(),
		.o_rise(p2_rise)
	);

	// ************************************************************
	// Helpers
	// ************************************************************
	// Returns {muxed, emitter three, two, one} for a slot code
	function automatic logic [3:0] decode_slot(input logic [3:0] code);
		logic [3:0] r;
		r = 4'h0;
		case (code)
			CODE_EMITTER_ONE: r = 4'b0001;
			CODE_EMITTER_TWO: r = 4'b0010;
			CODE_EMITTER_THREE: r = 4'b0100;
			CODE_MUXED_FOUR: r = 4'b1001;
			CODE_MUXED_FIVE: r = 4'b1010;
			CODE_MUXED_SIX: r = 4'b1100;
			default: r = 4'h0;
		endcase
		return r;
	endfunction : decode_slot

	function automatic logic [31:0] read_image(input oesc_state_s s,
			input logic [7:0] addr);
		logic [31:0] r;
		r = 32'h0;
		case ({addr[7:2], 2'b00})
			ADDR_CTRL: r[5:0] = s.ctrl;
			ADDR_SLOTS: r[11:0] = s.slots;
			ADDR_TIMING: r = {s.period, 8'h00, s.exp_ticks};
			ADDR_SYNC: r[3:0] = s.mode;
			ADDR_STATUS: begin
				r[1:0] = s.st;
				r[STATUS_SLOT_LSB +: 2] = s.slot;
				r[STATUS_BUSY_BIT] = (s.st != ST_IDLE);
				r[STATUS_CNT_LSB +: 16] = s.smp_cnt;
			end
			default: r = 32'h0;
		endcase
		return r;
	endfunction : read_image

	function automatic logic addr_ok(input logic [7:0] addr);
		logic [7:0] a;
		a = {addr[7:2], 2'b00};
		return a == ADDR_CTRL || a == ADDR_SLOTS || a == ADDR_TIMING ||
			a == ADDR_SYNC || a == ADDR_STATUS;
	endfunction : addr_ok

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		logic [31:0] merged;
		logic [1:0] nslots;
		logic [2:0] act;
		logic [3:0] dec [3];
		logic mux_any;
		logic [2:0] all_emit;
		logic all_mux;
		logic ext_clk;
		logic slave;
		logic master;
		logic mode_ok;
		logic tick;
		logic phase_end;
		logic start;
		logic last_slot;
		logic [CONV_W-1:0] comp;
		logic mux_level;
		merged = 32'h0;
		nslots = 2'd1;
		act = 3'b000;
		dec = '{default: 4'h0};
		mux_any = 1'b0;
		all_emit = 3'b000;
		all_mux = 1'b0;
		ext_clk = 1'b0;
		slave = 1'b0;
		master = 1'b0;
		mode_ok = 1'b0;
		tick = 1'b0;
		phase_end = 1'b0;
		start = 1'b0;
		last_slot = 1'b0;
		comp = '0;
		mux_level = 1'b1;
		n = q;
		n.fifo.valid = 1'b0;

		// Bus: address and data taken in either order
		if (i_s_axi_awvalid && q.awready) begin
			n.aw_have = 1'b1;
			n.awaddr = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && q.wready) begin
			n.w_have = 1'b1;
			n.wdata = i_s_axi_wdata;
			n.wstrb = i_s_axi_wstrb;
		end
		if (i_s_axi_bready && q.bvalid) begin
			n.bvalid = 1'b0;
		end
		if (q.aw_have && q.w_have && !q.bvalid) begin
			merged = read_image(q, q.awaddr);
			for (int b = 0; b < 4; b++) begin
				if (q.wstrb[b]) begin
					merged[b*8 +: 8] = q.wdata[b*8 +: 8];
				end
			end
			case ({q.awaddr[7:2], 2'b00})
				ADDR_CTRL: n.ctrl = merged[5:0];
				ADDR_SLOTS: n.slots = merged[11:0];
				ADDR_TIMING: begin
					n.exp_ticks = merged[7:0];
					n.period = merged[TIMING_PER_LSB +: 16];
				end
				ADDR_SYNC: n.mode = merged[3:0];
				default: n.mode = q.mode;
			endcase
			n.aw_have = 1'b0;
			n.w_have = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = addr_ok(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (i_s_axi_rready && q.rvalid) begin
			n.rvalid = 1'b0;
		end
		if (i_s_axi_arvalid && q.arready) begin
			n.rvalid = 1'b1;
			n.rdata = read_image(q, i_s_axi_araddr);
			n.rresp = addr_ok(i_s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		n.awready = !n.aw_have && !n.bvalid;
		n.wready = !n.w_have && !n.bvalid;
		n.arready = !n.rvalid;

		// Slot decode; a count of zero is taken as one
		nslots = (q.ctrl[CTRL_NSLOT_LSB +: 2] == 2'd0) ? 2'd1 :
			q.ctrl[CTRL_NSLOT_LSB +: 2];
		for (int i = 0; i < 3; i++) begin
			dec[i] = decode_slot(q.slots[i*4 +: 4]);
			act[i] = (2'(i) < nslots);
			if (act[i]) begin
				all_emit = all_emit | dec[i][2:0];
				all_mux = all_mux | dec[i][3];
			end
		end
		mux_any = all_mux;

		// Mode decode
		mode_ok = (q.mode <= MODE_MASTER_EXT);
		ext_clk = mode_ok && q.mode[0];
		slave = (q.mode == MODE_SLAVE_INT) || (q.mode == MODE_SLAVE_EXT);
		master = (q.mode == MODE_MASTER_INT) ||
			(q.mode == MODE_MASTER_EXT);

		// Timing tick: internal divider or external clock on pin two
		n.div_cnt = (q.div_cnt == OSC_DIV_LAST) ? 12'h0 :
			q.div_cnt + 12'h1;
		tick = ext_clk ? p2_rise : (q.div_cnt == OSC_DIV_LAST);

		// Trigger accepted only while idle, started on the next tick
		if (slave && p1_rise && q.st == ST_IDLE) begin
			n.trig_pend = 1'b1;
		end
		if (!slave || !q.ctrl[CTRL_EN_BIT]) begin
			n.trig_pend = 1'b0;
		end

		// Sample period counter for stand-alone and master modes
		if (tick) begin
			n.per_cnt = (q.per_cnt >= q.period - 16'h1) ? 16'h0 :
				q.per_cnt + 16'h1;
		end
		if (q.ctrl[CTRL_EN_BIT] && mode_ok && q.st == ST_IDLE && tick) begin
			start = slave ? q.trig_pend : (q.per_cnt == 16'h0);
		end

		// ************************************************************
		// Exposure sequencer
		// ************************************************************
		if (tick && q.st != ST_IDLE) begin
			phase_end = (q.tick_cnt + 8'h1 >= q.exp_ticks);
			n.tick_cnt = phase_end ? 8'h0 : q.tick_cnt + 8'h1;
		end
		last_slot = q.ctrl[CTRL_SIMUL_BIT] || (q.slot == nslots - 2'd1);
		comp = (i_conv_data >= q.dark) ? i_conv_data - q.dark : '0;
		case (q.st)
			ST_IDLE: begin
				if (start) begin
					n.st = ST_DARK;
					n.slot = 2'd0;
					n.tick_cnt = 8'h0;
					n.trig_pend = 1'b0;
					n.smp_cnt = q.smp_cnt + 16'h1;
				end
			end
			ST_DARK: begin
				if (phase_end) begin
					n.dark = i_conv_data;
					n.st = ST_LIT;
				end
			end
			ST_LIT: begin
				if (phase_end) begin
					n.fifo.valid = 1'b1;
					n.fifo.tag = TAG_EXPOSURE_BASE + 5'(q.slot);
					n.fifo.value = comp;
					if (!last_slot) begin
						n.slot = q.slot + 2'd1;
						n.st = ST_DARK;
					end else if (q.ctrl[CTRL_AMB_BIT]) begin
						n.st = ST_AMB;
					end else begin
						n.st = ST_IDLE;
					end
				end
			end
			ST_AMB: begin
				if (phase_end) begin
					n.fifo.valid = 1'b1;
					n.fifo.tag = TAG_AMBIENT;
					n.fifo.value = i_conv_data;
					n.st = ST_IDLE;
				end
			end
			default: n.st = ST_IDLE;
		endcase
		if (!q.ctrl[CTRL_EN_BIT] || !mode_ok) begin
			n.st = ST_IDLE;
		end

		// Emitters and mux level for the coming phase
		n.emit = 3'b000;
		if (n.st == ST_LIT) begin
			if (q.ctrl[CTRL_SIMUL_BIT]) begin
				n.emit = all_emit;
				mux_level = ~all_mux;
			end else begin
				n.emit = dec[n.slot][2:0];
				mux_level = ~dec[n.slot][3];
			end
		end

		// ************************************************************
		// Pin functions
		// ************************************************************
		n.pin1 = '{o: 1'b0, oe: 1'b0};
		n.pin2 = '{o: 1'b0, oe: 1'b0};
		case (q.mode)
			MODE_ALONE_INT, MODE_ALONE_EXT: begin
				n.pin1 = '{o: mux_level, oe: mux_any};
			end
			MODE_SLAVE_INT: begin
				n.pin2 = '{o: mux_level, oe: mux_any};
			end
			MODE_MASTER_INT, MODE_MASTER_EXT: begin
				// High through the first dark phase marks sample start
				n.pin1 = '{o: (n.st == ST_DARK && n.slot == 2'd0),
					oe: 1'b1};
				if (q.mode == MODE_MASTER_INT) begin
					n.pin2 = '{o: mux_level, oe: mux_any};
				end
			end
			default: n.pin1 = '{o: 1'b0, oe: 1'b0};
		endcase
		if (!master && !slave && !mode_ok) begin
			n.pin1 = '{o: 1'b0, oe: 1'b0};
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			q <= '0;
			q.ctrl <= CTRL_RESET;
			q.slots <= SLOTS_RESET;
			q.exp_ticks <= EXP_TICKS_RESET;
			q.period <= PERIOD_RESET;
			q.mode <= MODE_RESET;
			q.st <= ST_IDLE;
		end else begin
			q <= n;
		end
	end

	assign o_s_axi_awready = q.awready;
	assign o_s_axi_wready = q.wready;
	assign o_s_axi_bresp = q.bresp;
	assign o_s_axi_bvalid = q.bvalid;
	assign o_s_axi_arready = q.arready;
	assign o_s_axi_rdata = q.rdata;
	assign o_s_axi_rresp = q.rresp;
	assign o_s_axi_rvalid = q.rvalid;
	assign o_multipurpose_pin_one = q.pin1.o;
	assign o_multipurpose_pin_one_oe = q.pin1.oe;
	assign o_multipurpose_pin_two = q.pin2.o;
	assign o_multipurpose_pin_two_oe = q.pin2.oe;
	assign o_emitter = q.emit;
	assign o_fifo_valid = q.fifo.valid;
	assign o_fifo_data = {q.fifo.tag, q.fifo.value};
endmodule : oesc_top

// [test/oesc_assertions.sv]
// Checker of pin roles and FIFO pushes of the sequencer
`timescale 1ns/1ps
module oesc_assertions import oesc_pkg::*; (
	input wire logic i_mclk, // Clock
	input wire logic i_reset, // Reset
	input wire logic [7:0] i_s_axi_awaddr, // Write address
	input wire logic i_s_axi_awvalid, // Address valid
	input wire logic o_s_axi_awready, // Address ready
	input wire logic [31:0] i_s_axi_wdata, // Write data
	input wire logic i_s_axi_wvalid, // Data valid
	input wire logic o_s_axi_wready, // Data ready
	input wire logic o_multipurpose_pin_one, // Pin one level
	input wire logic o_multipurpose_pin_one_oe, // Pin one enable
	input wire logic o_multipurpose_pin_two, // Pin two level
	input wire logic o_multipurpose_pin_two_oe, // Pin two enable
	input wire logic [2:0] o_emitter, // Emitters
	input wire logic o_fifo_valid, // Push strobe
	input wire logic [23:0] o_fifo_data // Pushed entry
);
	// ****************
	// Shadow of the configuration seen on the bus
	// ****************
	logic [3:0] mode_q;
	logic [11:0] slots_q;
	logic [5:0] ctrl_q;
	logic [3:0] age_q;
	logic [1:0] nsl;
	logic wr_take, settled, mux_on, mux_any, mux_oe, mux_lvl, tag_ok;
	assign wr_take = i_s_axi_awvalid & o_s_axi_awready & i_s_axi_wvalid
		& o_s_axi_wready;
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			mode_q <= MODE_RESET;
			slots_q <= SLOTS_RESET;
			ctrl_q <= CTRL_RESET;
			age_q <= 4'h0;
		end else if (wr_take) begin
			age_q <= 4'h0;
			if (i_s_axi_awaddr == ADDR_SYNC) mode_q <= i_s_axi_wdata[3:0];
			if (i_s_axi_awaddr == ADDR_SLOTS) slots_q <= i_s_axi_wdata[11:0];
			if (i_s_axi_awaddr == ADDR_CTRL) ctrl_q <= i_s_axi_wdata[5:0];
		end else if (age_q != 4'hF) begin
			age_q <= age_q + 4'h1;
		end
	end
	// Pin roles judged only once a write has had time to land
	always_comb begin
		settled = (age_q == 4'hF);
		nsl = (ctrl_q[5:4] == 2'h0) ? 2'h1 : ctrl_q[5:4];
		mux_any = 1'b0;
		for (int i = 0; i < 3; i++) begin
			if (i < int'(nsl) && slots_q[4*i+:4] inside
				{[CODE_MUXED_FOUR:CODE_MUXED_SIX]})
				mux_any = 1'b1;
		end
		mux_on = settled && mode_q inside {4'h0, 4'h1, 4'h2, 4'h4};
		mux_oe = (mode_q < 4'h2) ? o_multipurpose_pin_one_oe
			: o_multipurpose_pin_two_oe;
		mux_lvl = (mode_q < 4'h2) ? o_multipurpose_pin_one
			: o_multipurpose_pin_two;
		tag_ok = (o_fifo_data[23:19] == TAG_AMBIENT) ? ctrl_q[2]
			: (o_fifo_data[23:19] != 5'h0
			&& o_fifo_data[23:19] <= (ctrl_q[1] ? 5'h1 : 5'(nsl)));
	end
	// ****************
	// Properties
	// ****************
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_reset);
	sequence s_lit_end;
		$fell(|o_emitter);
	endsequence
	sequence s_push_near;
		(o_fifo_valid || $past(o_fifo_valid)) or (##1 o_fifo_valid);
	endsequence
	property p_two_free;
		settled && mode_q inside {4'h0, 4'h1, 4'h3, 4'h5}
			|-> !o_multipurpose_pin_two_oe;
	endproperty
	a_two_free: assert property (p_two_free)
		else $error("pin two driven as clock input");
	property p_mux_en;
		mux_on |-> mux_oe == mux_any;
	endproperty
	a_mux_en: assert property (p_mux_en)
		else $error("mux pin enable wrong");
	property p_mux_idle;
		mux_on && mux_any && o_emitter == 3'h0 && $stable(o_emitter)
			|-> mux_lvl;
	endproperty
	a_mux_idle: assert property (p_mux_idle)
		else $error("mux pin low outside muxed exposure");
	property p_mux_lit;
		mux_on && ctrl_q[1] && mux_any && |o_emitter && $stable(o_emitter)
			|-> !mux_lvl;
	endproperty
	a_mux_lit: assert property (p_mux_lit)
		else $error("mux pin high in muxed exposure");
	property p_trig_in;
		settled && mode_q inside {4'h2, 4'h3} |-> !o_multipurpose_pin_one_oe;
	endproperty
	a_trig_in: assert property (p_trig_in)
		else $error("trigger pin driven");
	property p_master;
		settled && mode_q inside {4'h4, 4'h5} |-> o_multipurpose_pin_one_oe;
	endproperty
	a_master: assert property (p_master)
		else $error("master output not driven");
	property p_off;
		settled && mode_q > 4'h5 |-> !(o_multipurpose_pin_one_oe
			|| o_multipurpose_pin_two_oe || o_fifo_valid);
	endproperty
	a_off: assert property (p_off)
		else $error("unused mode not idle");
	property p_lit_push;
		s_lit_end |-> s_push_near;
	endproperty
	a_lit_push: assert property (p_lit_push)
		else $error("lit exposure without push");
	property p_pulse;
		o_fifo_valid |=> !o_fifo_valid;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("push strobe too long");
	property p_tag;
		o_fifo_valid |-> tag_ok;
	endproperty
	a_tag: assert property (p_tag)
		else $error("bad entry tag");
endmodule : oesc_assertions
bind oesc_top oesc_assertions u_chk (.i_mclk(i_mclk), .i_reset(i_reset),
	.i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_awvalid(i_s_axi_awvalid),
	.o_s_axi_awready(o_s_axi_awready), .i_s_axi_wdata(i_s_axi_wdata),
	.i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
	.o_multipurpose_pin_one(o_multipurpose_pin_one),
	.o_multipurpose_pin_one_oe(o_multipurpose_pin_one_oe),
	.o_multipurpose_pin_two(o_multipurpose_pin_two),
	.o_multipurpose_pin_two_oe(o_multipurpose_pin_two_oe),
	.o_emitter(o_emitter), .o_fifo_valid(o_fifo_valid),
	.o_fifo_data(o_fifo_data));

// [test/oesc_partner.sv]
// Model of the link clock source and trigger master on the pins
`timescale 1ns/1ps
module oesc_partner (
	input wire logic i_run, // Link clock on
	input wire logic i_trig, // Trigger level
	input wire logic i_one_o, // Pin one drive
	input wire logic i_one_oe, // Pin one enable
	input wire logic i_two_o, // Pin two drive
	input wire logic i_two_oe, // Pin two enable
	output logic o_one, // Pin one wire
	output logic o_two // Pin two wire
);
	logic lclk = 1'b0;
	// Clock stands still while off; pull-up then holds the line
	always #62.5 lclk = i_run ? ~lclk : 1'b0;
	assign o_one = i_one_oe ? i_one_o : i_trig;
	assign o_two = i_two_oe ? i_two_o : (i_run ? lclk : 1'b1);
endmodule : oesc_partner

// [test/oesc_top_bench.sv]
// Self-checking bench of the exposure sequencer and pin control
`timescale 1ns/1ps
module oesc_top_bench import oesc_pkg::*;;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic run = 1'b0;
	logic trig = 1'b0;
	logic [CONV_W-1:0] conv = '0;
	logic awready, wready, bvalid, arready, rvalid, fvalid;
	logic one_w, one_o, one_oe, two_w, two_o, two_oe;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [2:0] emit;
	logic [23:0] fdata;
	logic [18:0] dark, lbase;
	logic [18:0] lv [3];
	logic [23:0] got_q [$];
	logic [23:0] exp_q [$];
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	initial forever #4 mclk = ~mclk;
	oesc_top DUT (.i_mclk(mclk), .i_reset(rst), .i_s_axi_awaddr(awaddr),
		.i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
		.i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
		.o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
		.i_s_axi_rready(rready), .i_multipurpose_pin_one(one_w),
		.o_multipurpose_pin_one(one_o), .o_multipurpose_pin_one_oe(one_oe),
		.i_multipurpose_pin_two(two_w), .o_multipurpose_pin_two(two_o),
		.o_multipurpose_pin_two_oe(two_oe), .o_emitter(emit),
		.i_conv_data(conv), .o_fifo_valid(fvalid), .o_fifo_data(fdata));
	oesc_partner u_far (.i_run(run), .i_trig(trig), .i_one_o(one_o),
		.i_one_oe(one_oe), .i_two_o(two_o), .i_two_oe(two_oe),
		.o_one(one_w), .o_two(two_w));
	// ****************
	// Converter model, FIFO monitor, watchdog
	// ****************
	always @(posedge mclk) conv <= |emit ? lit_of(emit) : dark;
	always @(posedge mclk) if (fvalid === 1'b1) got_q.push_back(fdata);
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 100000) begin
			error_cnt++;
			wrap_up();
		end
	end
	function automatic logic [18:0] lit_of(input logic [2:0] e);
		lit_of = lbase;
		for (int i = 0; i < 3; i++)
			if (e[i]) lit_of = lit_of + lv[i];
	endfunction : lit_of
	// Muxed emitters reuse drivers one to three
	function automatic logic [2:0] emit_of(input logic [3:0] c);
		emit_of = 3'h1 << ((c > 4'h9) ? c - 4'hA : c - 4'h1);
	endfunction : emit_of
	function automatic logic [23:0] ent(input logic [4:0] t, logic [2:0] e);
		ent = {t, (lit_of(e) > dark) ? lit_of(e) - dark : 19'h0};
	endfunction : ent
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd
	// ****************
	// One configuration run with its expected FIFO stream
	// ****************
	task automatic scen(input logic [3:0] md, input logic [5:0] ct,
		input logic [11:0] sl, input logic [15:0] per, input int ns);
		logic [1:0] r;
		logic [2:0] em;
		int n;
		n = (ct[5:4] == 2'h0) ? 1 : int'(ct[5:4]);
		dark = 19'($urandom_range(0, 'h1FFFF));
		lbase = 19'($urandom_range(0, 'h1FFFF));
		for (int i = 0; i < 3; i++) lv[i] = 19'($urandom_range(0, 'hFFFF));
		exp_q.delete();
		repeat (ns) begin
			em = 3'h0;
			for (int i = 0; i < n; i++) begin
				em = ct[1] ? em | emit_of(sl[4*i+:4]) : emit_of(sl[4*i+:4]);
				if (!ct[1]) exp_q.push_back(ent(TAG_EXPOSURE_BASE + 5'(i), em));
			end
			if (ct[1]) exp_q.push_back(ent(TAG_EXPOSURE_BASE, em));
			if (ct[2]) exp_q.push_back({TAG_AMBIENT, dark});
		end
		axi_wr(ADDR_SYNC, {28'h0, md}, r);
		axi_wr(ADDR_SLOTS, {20'h0, sl}, r);
		axi_wr(ADDR_TIMING, {per, 16'h0004}, r);
		got_q.delete();
		run <= md[0];
		axi_wr(ADDR_CTRL, {26'h0, ct | 6'h01}, r);
		// Second pulse lands mid-sample and must be ignored
		if (md == MODE_SLAVE_EXT) repeat (2) begin
			@(posedge mclk);
			trig <= 1'b1;
			repeat (30) @(posedge mclk);
			trig <= 1'b0;
			repeat (60) @(posedge mclk);
		end
		for (int k = 0; k < 40000 && got_q.size() < exp_q.size(); k++)
			@(posedge mclk);
		axi_wr(ADDR_CTRL, {26'h0, ct}, r);
		repeat (300) @(posedge mclk);
		chk("count", 32'(got_q.size()), 32'(exp_q.size()));
		foreach (exp_q[i]) chk("entry", 32'(got_q[i]), 32'(exp_q[i]));
		run <= 1'b0;
	endtask : scen
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [3:0] c [6];
		c = '{4'h1, 4'h2, 4'h3, 4'hA, 4'hB, 4'hC};
		void'($urandom(88));
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		repeat (3) @(posedge mclk);
		axi_rd(ADDR_CTRL, d, r);
		chk("ctrl", d, {26'h0, CTRL_RESET});
		axi_rd(ADDR_TIMING, d, r);
		chk("timing", d, {PERIOD_RESET, 8'h0, EXP_TICKS_RESET});
		axi_rd(8'h40, d, r);
		chk("unmapped", d, 32'h0);
		chk("rresp", 32'(r), 32'(RESP_SLVERR));
		axi_wr(8'h40, 32'hFFFFFFFF, r);
		chk("bresp", 32'(r), 32'(RESP_SLVERR));
		for (int m = 0; m < 16; m++) begin
			axi_wr(ADDR_SLOTS, {20'h0, 8'h0, c[$urandom_range(0, 5)]}, r);
			axi_wr(ADDR_SYNC, 32'(m), r);
			repeat (20) @(posedge mclk);
			axi_rd(ADDR_SYNC, d, r);
			chk("sync", d, 32'(m));
		end
		scen(MODE_ALONE_EXT, 6'h10, 12'h001, 16'h0040, 2);
		scen(MODE_SLAVE_EXT, 6'h36, 12'h321, 16'h0040, 1);
		scen(MODE_MASTER_EXT, 6'h34, 12'hCB1, 16'h0040, 1);
		scen(MODE_ALONE_INT, 6'h22, 12'h0A2, 16'h0002, 1);
		repeat (6) begin
			scen($urandom_range(0, 1) ? MODE_SLAVE_EXT : MODE_MASTER_EXT,
				{2'($urandom_range(1, 3)), 1'b0, 2'($urandom_range(0, 3)), 1'b0},
				{c[$urandom_range(0, 5)], c[$urandom_range(0, 5)],
				c[$urandom_range(0, 5)]}, 16'h0040, 1);
		end
		wrap_up();
	end
endmodule : oesc_top_bench
